// >>> rtl/agpc_pkg.sv
package agpc_pkg;
    // Printed offsets are not all multiples of four, so they are indices.
    localparam logic [7:0] IDX_CHAN_A_GAIN = 8'h0c;
    localparam logic [7:0] IDX_CHAN_B_GAIN = 8'h0d;
    localparam logic [7:0] IDX_WORD_HIGH = 8'h0e;
    localparam logic [7:0] IDX_WORD_LOW = 8'h0f;
    localparam logic [7:0] IDX_SLOW_CTRL = 8'h13;
    localparam logic [7:0] IDX_POWER_CTRL = 8'h15;
    localparam logic [7:0] IDX_CLK_DIV = 8'h27;
    // Pattern selectors, coined register for the shared selector codes.
    localparam logic [7:0] IDX_PATTERN_SEL = 8'h0a;
    // Field positions.
    localparam int POS_SLOW = 7;
    localparam int POS_CHA_PD = 6;
    localparam int POS_CHB_PD = 5;
    localparam int POS_STANDBY = 3;
    localparam int POS_GLOBAL_PD = 2;
    localparam int POS_OVERRIDE = 0;
    // Field masks of the writable bits; all others are dropped on write and read as zero.
    localparam logic [7:0] MASK_A_GAIN = 8'h0f;
    localparam logic [7:0] MASK_B_GAIN = 8'hf0;
    localparam logic [7:0] MASK_WORD_LOW = 8'hfc;
    localparam logic [7:0] MASK_SLOW = 8'h80;
    localparam logic [7:0] MASK_POWER = 8'h6d;
    localparam logic [7:0] MASK_CLK_DIV = 8'hc0;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // Highest defined gain code (6 dB), in half-dB steps.
    localparam logic [3:0] GAIN_MAX = 4'hc;
    localparam logic [3:0] PATTERN_CUSTOM = 4'h5;
    localparam int WORD_BITS = 14;
    // Divider codes.
    typedef enum logic [1:0] {
        AGPC_DIV_BYPASS = 2'h0,
        AGPC_DIV_1 = 2'h1,
        AGPC_DIV_2 = 2'h2,
        AGPC_DIV_4 = 2'h3
    } agpc_div_t;
    // Decoded power controls travel together.
    typedef struct packed {
        logic chan_a_down;
        logic chan_b_down;
        logic standby;
        logic global_down;
    } agpc_power_t;
endpackage : agpc_pkg

// >>> rtl/agpc_regs.sv
module agpc_regs
    import agpc_pkg::*;
#(
    parameter int AW = 8
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [AW+1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    input wire logic powerdown_pin,
    input wire logic [13:0] chan_a_sample,
    input wire logic [13:0] chan_b_sample,
    output logic [13:0] chan_a_data,
    output logic [13:0] chan_b_data,
    output logic [4:0] chan_a_gain_half_db,
    output logic [4:0] chan_b_gain_half_db,
    output logic chan_a_gain_bad,
    output logic chan_b_gain_bad,
    output logic slow_sampling,
    output logic chan_a_off,
    output logic chan_b_off,
    output logic standby_out,
    output logic global_off,
    output logic [1:0] clk_div_sel,
    output logic clk_div_pulse
);
    // Register storage, all cleared by reset.
    logic [7:0] chan_a_gain_r;
    logic [7:0] chan_b_gain_r;
    logic [7:0] word_high_r;
    logic [7:0] word_low_r;
    logic [7:0] slow_r;
    logic [7:0] power_r;
    logic [7:0] clk_div_r;
    logic [7:0] pattern_r;
    logic ack_r;
    logic [31:0] rdata_r;
    // Pin synchroniser; only the second stage is read by logic.
    logic pin_meta_r;
    logic pin_sync_r;
    // Divider counter and output flops.
    logic [1:0] div_cnt_r;
    logic div_pulse_r;
    logic [13:0] a_data_r;
    logic [13:0] b_data_r;
    agpc_power_t pwr_r;
    agpc_power_t pwr_nxt;
    logic [4:0] a_db_r;
    logic [4:0] b_db_r;
    logic a_bad_r;
    logic b_bad_r;

    // Convert a gain code to half-dB units; codes above 6 dB convert to zero.
    function automatic logic [4:0] gain_half_db(input logic [3:0] code);
        return (code > GAIN_MAX) ? 5'h00 : {1'b0, code};
    endfunction : gain_half_db

    // Word decode; byte-lane 0 carries all data, registers are 8 bits wide.
    wire logic [AW-1:0] idx = wb_adr_i[AW+1:2];
    wire logic req = wb_cyc_i & wb_stb_i & ~ack_r;
    // A write lands at the edge where the master samples ack high, not one edge earlier.
    // This keeps the register and the bus handshake on the same edge for the master.
    wire logic wr = wb_cyc_i & wb_stb_i & ack_r & wb_we_i & wb_sel_i[0];
    wire logic [7:0] wd = wb_dat_i[7:0];
    wire logic hit_a = (idx == IDX_CHAN_A_GAIN);
    wire logic hit_b = (idx == IDX_CHAN_B_GAIN);
    wire logic hit_wh = (idx == IDX_WORD_HIGH);
    wire logic hit_wl = (idx == IDX_WORD_LOW);
    wire logic hit_sl = (idx == IDX_SLOW_CTRL);
    wire logic hit_pw = (idx == IDX_POWER_CTRL);
    wire logic hit_cd = (idx == IDX_CLK_DIV);
    wire logic hit_ps = (idx == IDX_PATTERN_SEL);
    // Shared custom word assembled from both halves.
    wire logic [13:0] user_word = {word_high_r, word_low_r[7:2]};
    wire logic override = power_r[POS_OVERRIDE];
    wire agpc_div_t div_code = agpc_div_t'(clk_div_r[7:6]);

    // Read mux; unmapped indices read as zero.
    wire logic [7:0] rmux =
        hit_a ? chan_a_gain_r : hit_b ? chan_b_gain_r : hit_wh ? word_high_r :
        hit_wl ? word_low_r : hit_sl ? slow_r : hit_pw ? power_r :
        hit_cd ? clk_div_r : hit_ps ? pattern_r : RESET_VALUE;

    // Bus answer: ack one cycle after the request, dropped the next cycle.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end
        else
        begin
            ack_r <= req;
            rdata_r <= {24'h00_0000, rmux};
        end
    end

    // Register writes; only writable bits are kept.
    // reserved bits dropped.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            chan_a_gain_r <= RESET_VALUE;
            chan_b_gain_r <= RESET_VALUE;
            word_high_r <= RESET_VALUE;
            word_low_r <= RESET_VALUE;
            slow_r <= RESET_VALUE;
            power_r <= RESET_VALUE;
            clk_div_r <= RESET_VALUE;
            pattern_r <= RESET_VALUE;
        end
        else if (wr)
        begin
            if (hit_a) chan_a_gain_r <= wd & MASK_A_GAIN;
            if (hit_b) chan_b_gain_r <= wd & MASK_B_GAIN;
            if (hit_wh) word_high_r <= wd & MASK_ALL;
            if (hit_wl) word_low_r <= wd & MASK_WORD_LOW;
            if (hit_sl) slow_r <= wd & MASK_SLOW;
            if (hit_pw) power_r <= wd & MASK_POWER;
            if (hit_cd) clk_div_r <= wd & MASK_CLK_DIV;
            if (hit_ps) pattern_r <= wd;
        end
    end

    // Power decode. The pin is a cross-domain level, so it is synchronised.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= powerdown_pin;
            pin_sync_r <= pin_meta_r;
        end
    end

    always_comb
    begin
        // channel A down gated by override.
        pwr_nxt.chan_a_down = override & power_r[POS_CHA_PD];
        // channel B down gated by override.
        pwr_nxt.chan_b_down = override & power_r[POS_CHB_PD];
        pwr_nxt.standby = power_r[POS_STANDBY];
        // global down from register, plus pin unless overridden.
        pwr_nxt.global_down = power_r[POS_GLOBAL_PD] | (~override & pin_sync_r);
    end

    // Divider: one-cycle enable pulse at the selected rate.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            div_cnt_r <= 2'h0;
            div_pulse_r <= 1'b0;
        end
        else
        begin
            unique case (div_code)
                AGPC_DIV_BYPASS, AGPC_DIV_1:
                begin
                    div_cnt_r <= 2'h0;
                    div_pulse_r <= 1'b1;
                end
                AGPC_DIV_2:
                begin
                    div_cnt_r <= {1'b0, ~div_cnt_r[0]};
                    div_pulse_r <= (div_cnt_r[0] == 1'b0);
                end
                AGPC_DIV_4:
                begin
                    div_cnt_r <= div_cnt_r + 2'h1;
                    div_pulse_r <= (div_cnt_r == 2'h0);
                end
            endcase
        end
    end

    // Output flops: power, gain, data path.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pwr_r <= '0;
            a_db_r <= 5'h00;
            b_db_r <= 5'h00;
            a_bad_r <= 1'b0;
            b_bad_r <= 1'b0;
            a_data_r <= 14'h0000;
            b_data_r <= 14'h0000;
        end
        else
        begin
            pwr_r <= pwr_nxt;
            a_db_r <= gain_half_db(chan_a_gain_r[3:0]);
            b_db_r <= gain_half_db(chan_b_gain_r[7:4]);
            a_bad_r <= chan_a_gain_r[3:0] > GAIN_MAX;
            b_bad_r <= chan_b_gain_r[7:4] > GAIN_MAX;
            a_data_r <= (pattern_r[3:0] == PATTERN_CUSTOM) ? user_word : chan_a_sample;
            b_data_r <= (pattern_r[7:4] == PATTERN_CUSTOM) ? user_word : chan_b_sample;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign chan_a_data = a_data_r;
    assign chan_b_data = b_data_r;
    assign chan_a_gain_half_db = a_db_r;
    assign chan_b_gain_half_db = b_db_r;
    assign chan_a_gain_bad = a_bad_r;
    assign chan_b_gain_bad = b_bad_r;
    assign slow_sampling = slow_r[POS_SLOW];
    assign chan_a_off = pwr_r.chan_a_down;
    assign chan_b_off = pwr_r.chan_b_down;
    assign standby_out = pwr_r.standby;
    assign global_off = pwr_r.global_down;
    assign clk_div_sel = clk_div_r[7:6];
    assign clk_div_pulse = div_pulse_r;

    // Checks.
    a_cha_pd_gate: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> chan_a_off == $past(override & power_r[POS_CHA_PD]))
        else $error("Channel A down mismatch");
    a_chb_pd_gate: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> chan_b_off == $past(power_r[POS_OVERRIDE] & power_r[POS_CHB_PD]))
        else $error("Channel B down mismatch");
    a_standby_follow: assert property (@(posedge mclk) disable iff (rst)
        ##1 standby_out == $past(power_r[POS_STANDBY])) else $error("Standby mismatch");
    a_global_reg: assert property (@(posedge mclk) disable iff (rst)
        power_r[POS_GLOBAL_PD] |=> global_off) else $error("Global down not applied");
    a_pin_ignored: assert property (@(posedge mclk) disable iff (rst)
        (override && !power_r[POS_GLOBAL_PD]) |=> !global_off) else $error("Pin not ignored");
    a_gain_a_store: assert property (@(posedge mclk) disable iff (rst)
        (wr && hit_a) |=> chan_a_gain_r == ($past(wd) & MASK_A_GAIN)) else $error("Gain A store");
    a_gain_b_store: assert property (@(posedge mclk) disable iff (rst)
        (wr && hit_b) |=> chan_b_gain_r[3:0] == 4'h0) else $error("Gain B reserved bits");
    a_word_low_rsv: assert property (@(posedge mclk) disable iff (rst)
        word_low_r[1:0] == 2'h0) else $error("Word low reserved bits set");
    a_custom_out: assert property (@(posedge mclk) disable iff (rst)
        (pattern_r[3:0] == PATTERN_CUSTOM) ##1 (pattern_r[3:0] == PATTERN_CUSTOM)
        |-> chan_a_data == $past(user_word)) else $error("Custom word not output");
    a_ack_one: assert property (@(posedge mclk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o) else $error("Ack longer than one cycle");
    a_div4_rate: assert property (@(posedge mclk) disable iff (rst)
        (div_code == AGPC_DIV_4) [*5] |-> $countones({$past(div_pulse_r, 3),
        $past(div_pulse_r, 2), $past(div_pulse_r), div_pulse_r}) == 1)
        else $error("Divide-by-4 rate wrong");
endmodule : agpc_regs

// >>> verif/agpc_regs_tb.sv
module agpc_regs_tb
    import agpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Bus, pin and sample stimulus; every design input is driven from here.
    logic mclk, rst, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, powerdown_pin;
    logic [9:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0] wb_sel_i;
    logic [13:0] chan_a_sample, chan_b_sample, chan_a_data, chan_b_data, word;
    logic [4:0] chan_a_gain_half_db, chan_b_gain_half_db;
    logic chan_a_gain_bad, chan_b_gain_bad, slow_sampling, chan_a_off, chan_b_off;
    logic standby_out, global_off, clk_div_pulse;
    logic [1:0] clk_div_sel;
    int miscompares, tests_run, cnt;
    // Reference image of every register, kept by the bench from writes and resets alone.
    logic [7:0] mdl [0:255];
    logic [7:0] idx_tab [0:7] = '{IDX_CHAN_A_GAIN, IDX_CHAN_B_GAIN, IDX_WORD_HIGH,
        IDX_WORD_LOW, IDX_SLOW_CTRL, IDX_POWER_CTRL, IDX_CLK_DIV, IDX_PATTERN_SEL};
    logic [7:0] mask_tab [0:7] = '{MASK_A_GAIN, MASK_B_GAIN, MASK_ALL, MASK_WORD_LOW,
        MASK_SLOW, MASK_POWER, MASK_CLK_DIV, MASK_ALL};

    agpc_regs agpc_regs_inst (.mclk(mclk), .rst(rst), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .powerdown_pin(powerdown_pin), .chan_a_sample(chan_a_sample),
        .chan_b_sample(chan_b_sample), .chan_a_data(chan_a_data), .chan_b_data(chan_b_data),
        .chan_a_gain_half_db(chan_a_gain_half_db), .chan_b_gain_half_db(chan_b_gain_half_db),
        .chan_a_gain_bad(chan_a_gain_bad), .chan_b_gain_bad(chan_b_gain_bad),
        .slow_sampling(slow_sampling), .chan_a_off(chan_a_off), .chan_b_off(chan_b_off),
        .standby_out(standby_out), .global_off(global_off), .clk_div_sel(clk_div_sel),
        .clk_div_pulse(clk_div_pulse));

    // The 125 MHz system clock.
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // One comparison; an unknown on the design side never matches.
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // The single place where the run ends.
    task summarize;
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize

    // Writable-bit mask of an index; unmapped places keep nothing.
    function automatic logic [7:0] msk(input logic [7:0] idx);
        msk = 8'h00;
        for (int k = 0; k < 8; k++)
            if (idx_tab[k] == idx)
                msk = mask_tab[k];
    endfunction : msk

    // Classic single cycle: request held until ack is sampled high, then released.
    task wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_sel_i <= s;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h00_0000, d};
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // A missing ack is counted and ends the run instead of hanging.
        if (n >= 50)
        begin
            miscompares++;
            summarize();
        end
    endtask : wb

    // Write and track the model; a write without byte lane 0 is ignored.
    task wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] s);
        wb(1'b1, idx, d, s);
        if (s[0])
            mdl[idx] = d & msk(idx);
    endtask : wr

    task rd(input logic [7:0] idx);
        wb(1'b0, idx, 8'h00, 4'hf);
        chk(q, {24'h00_0000, mdl[idx]});
    endtask : rd

    // Reset the design and the model together; reset is asynchronous.
    task do_reset(input int n);
        rst <= 1'b1;
        repeat (n) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 256; k++)
            mdl[k] = 8'h00;
        for (int k = 0; k < 8; k++)
            rd(idx_tab[k]);
    endtask : do_reset

    // Decoded outputs against the model; the task first waits five cycles for them to settle.
    task chk_outs;
        logic [3:0] ga, gb;
        logic [7:0] pw;
        ga = mdl[IDX_CHAN_A_GAIN][3:0];
        gb = mdl[IDX_CHAN_B_GAIN][7:4];
        pw = mdl[IDX_POWER_CTRL];
        repeat (5) @(posedge mclk);
        chk(chan_a_gain_half_db, (ga > GAIN_MAX) ? 4'h0 : ga);
        chk(chan_a_gain_bad, ga > GAIN_MAX);
        chk(chan_b_gain_half_db, (gb > GAIN_MAX) ? 4'h0 : gb);
        chk(chan_b_gain_bad, gb > GAIN_MAX);
        chk(slow_sampling, mdl[IDX_SLOW_CTRL][7]);
        chk(chan_a_off, pw[6] & pw[0]);
        chk(chan_b_off, pw[5] & pw[0]);
        chk(standby_out, pw[3]);
        chk(global_off, pw[2] | (~pw[0] & powerdown_pin));
        chk(clk_div_sel, mdl[IDX_CLK_DIV][7:6]);
    endtask : chk_outs

    initial
    begin
        {wb_cyc_i, wb_stb_i, wb_we_i, powerdown_pin} = 4'h0;
        {wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        chan_a_sample = 14'h0000;
        chan_b_sample = 14'h0000;
        miscompares = 0;
        tests_run = 0;
        rst = 1'b1;
        void'($urandom(32'hd2f5));
        do_reset(20);
        rd(8'h3f);
        // Random writes carry reserved bits and random lanes; pin level moves too.
        repeat (80)
        begin
            cnt = $urandom_range(7);
            powerdown_pin <= 1'($urandom);
            wr(idx_tab[cnt], 8'($urandom), 4'($urandom));
            rd(idx_tab[cnt]);
            chk_outs();
        end
        wr(8'h3f, 8'hff, 4'hf);
        rd(8'h3f);
        // Every gain code, the undefined ones included.
        for (int c = 0; c < 16; c++)
        begin
            wr(IDX_CHAN_A_GAIN, 8'(c), 4'hf);
            wr(IDX_CHAN_B_GAIN, 8'((15 - c) << 4), 4'hf);
            chk_outs();
        end
        // Divider strobe rate over eight cycles for each code.
        for (int d = 0; d < 4; d++)
        begin
            // Software side keeps to defined divider codes with reserved bits at zero.
            wr(IDX_CLK_DIV, 8'(d << 6), 4'hf);
            repeat (4) @(posedge mclk);
            cnt = 0;
            repeat (8) @(posedge mclk) cnt += int'(clk_div_pulse);
            chk(cnt, (d == 3) ? 2 : (d == 2) ? 4 : 8);
        end
        // Shared user word reaches only the channel whose selector asks for it.
        wr(IDX_WORD_HIGH, 8'($urandom), 4'hf);
        wr(IDX_WORD_LOW, 8'($urandom), 4'hf);
        word = {mdl[IDX_WORD_HIGH], mdl[IDX_WORD_LOW][7:2]};
        foreach (idx_tab[k])
        begin
            chan_a_sample <= 14'($urandom);
            chan_b_sample <= 14'($urandom);
            wr(IDX_PATTERN_SEL, (k[1] ? 8'h50 : 8'h00) | (k[0] ? 8'h05 : 8'h00), 4'hf);
            repeat (4) @(posedge mclk);
            chk(chan_a_data, k[0] ? word : chan_a_sample);
            chk(chan_b_data, k[1] ? word : chan_b_sample);
        end
        // A second reset in mid-run clears every field again.
        do_reset(3);
        chk_outs();
        summarize();
    end
endmodule : agpc_regs_tb
